// file: core/tms_map.vh
`ifndef TMS_MAP_VH
`define TMS_MAP_VH
// clock and base tick (fastest conversion rate)
`define TMS_CLK_HZ     10000000
`define TMS_TICK_HZ    64
// channels: 0 internal, 1..4 external
`define TMS_LAST_CH    3'h4
// register byte offsets
`define TMS_OFF_CFG    8'h00
`define TMS_OFF_RATE   8'h04
`define TMS_OFF_ONESHOT 8'h08
`define TMS_OFF_HIGH   8'h0C
`define TMS_OFF_LOW    8'h10
`define TMS_OFF_THERM  8'h14
`define TMS_OFF_HYST   8'h18
`define TMS_OFF_CONSEC 8'h1C
`define TMS_OFF_SHSEL  8'h20
`define TMS_OFF_APD    8'h24
`define TMS_OFF_BETA   8'h28
`define TMS_OFF_STATUS 8'h2C
`define TMS_OFF_STATE  8'h30
`define TMS_OFF_THSTAT 8'h34
`define TMS_RES_WORD   6'h10
`define TMS_RES_COUNT  6'h05
// synchroniser reset: pins idle high under their pull-ups, codes zero
`define TMS_SYNC_RST   13'h000F
// config bit positions
`define TMS_CFG_STBY   0
`define TMS_CFG_ATHM   1
`define TMS_CFG_MASK   2
// reset values
`define TMS_RST_RATE   4'h6
`define TMS_RST_HIGH   8'h55
`define TMS_RST_LOW    8'h00
`define TMS_RST_THERM  8'h64
`define TMS_RST_HYST   8'h0A
`define TMS_RST_CONSEC 3'h4
// rate decode
`define TMS_RATE_1HZ   4'h4
`define TMS_RATE_MAX   4'hA
`define TMS_PER_SLOW   11'h400
`define TMS_PER_1HZ    11'h040
// shutdown limit decode and fixed hysteresis
`define TMS_SHDN_BASE  8'h3C
`define TMS_SHDN_HYST  9'h00A
`define TMS_ADDR_BASE  7'h4C
`define TMS_STRAP_AT   2'h2
// bus responses
`define TMS_RESP_OK    2'h0
`define TMS_RESP_ERR   2'h2
`endif

// file: core/tms_ctrl.v
// Our own choices: register access over AXI4-Lite and the register addresses.
`default_nettype none
`include "tms_map.vh"

module tms_ctrl #(
    parameter [0:0] HAS_SHDN    = 1'h1,
    parameter [0:0] ADDR_DECODE = 1'h1,
    parameter       TICK_CYCLES = `TMS_CLK_HZ / `TMS_TICK_HZ
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        scl_in,
    output reg         meas_start,
    output reg  [2:0]  meas_chan,
    input  wire        meas_done,
    input  wire [7:0]  meas_temp,
    input  wire        meas_fault,
    input  wire        alert_in,
    output wire        alert_out,
    output reg         alert_oe_n,
    input  wire        therm_in,
    output wire        therm_out,
    output reg         therm_oe_n,
    input  wire        hw_shutdown_pin_in,
    output wire        hw_shutdown_pin_out,
    output reg         hw_shutdown_pin_oe_n,
    input  wire [2:0]  shdn_pu_code,
    input  wire [2:0]  alert_pu_code,
    input  wire [2:0]  therm_pu_code,
    output reg  [6:0]  client_addr,
    output reg  [3:0]  beta_en
);

    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_MEAS = 2'h1;
    localparam [1:0] S_WAIT = 2'h2;
    localparam [31:0] TICK_CYC32 = TICK_CYCLES;

    // two-flop synchronisers for pins and pull-up detector codes
    reg  [12:0] sync1;
    reg  [12:0] sync2;
    reg         scl_d;
    reg  [15:0] scl_edges;
    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= `TMS_SYNC_RST;
            sync2 <= `TMS_SYNC_RST;
        end else begin
            sync1 <= {therm_pu_code, alert_pu_code, shdn_pu_code,
                      hw_shutdown_pin_in, therm_in, alert_in, scl_in};
            sync2 <= sync1;
        end
    end
    wire       scl_s   = sync2[0];
    wire [2:0] shdn_cd = sync2[6:4];
    wire [2:0] alrt_cd = sync2[9:7];
    wire [2:0] thrm_cd = sync2[12:10];

    // link clock edge counter
    always @(posedge aclk) begin
        if (!aresetn) begin
            scl_d     <= 1'h1;
            scl_edges <= 16'h0000;
        end else begin
            scl_d <= scl_s;
            if (scl_s && !scl_d)
                scl_edges <= scl_edges + 16'h0001;
        end
    end

    // configuration registers
    reg  [2:0] cfg;
    reg  [3:0] rate_select;
    reg  [7:0] lim_high;
    reg  [7:0] lim_low;
    reg  [7:0] lim_therm;
    reg  [7:0] hyst;
    reg  [2:0] consec;
    reg  [4:0] shsel;
    reg  [1:0] antiparallel_pair_mode;
    reg  [3:0] beta_req;
    reg  [7:0] shdn_lim;
    reg  [1:0] strap_cnt;
    reg        os_pend;

    // pull-up straps caught after reset release
    always @(posedge aclk) begin
        if (!aresetn) begin
            strap_cnt   <= 2'h0;
            shdn_lim    <= `TMS_SHDN_BASE;
            client_addr <= `TMS_ADDR_BASE;
        end else if (strap_cnt != 2'h3) begin
            strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == `TMS_STRAP_AT) begin
                shdn_lim <= `TMS_SHDN_BASE + {2'h0, shdn_cd, alrt_cd};
                if (ADDR_DECODE)
                    client_addr <= `TMS_ADDR_BASE + {4'h0, thrm_cd};
            end
        end
    end

    wire standby = cfg[`TMS_CFG_STBY];
    wire [3:0] rate_eff = (HAS_SHDN && rate_select < `TMS_RATE_1HZ) ?
                          `TMS_RATE_1HZ : rate_select;
    wire [10:0] period = (rate_eff <= `TMS_RATE_MAX) ?
                         (`TMS_PER_SLOW >> rate_eff) : `TMS_PER_1HZ;

    // AXI4-Lite write channel
    reg  [7:0]  aw_q;
    reg  [31:0] w_q;
    reg         wstb_q;
    wire        do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    reg         wr_ok;
    always @* begin
        case ({aw_q[7:2], 2'h0})
            `TMS_OFF_CFG, `TMS_OFF_RATE, `TMS_OFF_ONESHOT, `TMS_OFF_HIGH,
            `TMS_OFF_LOW, `TMS_OFF_THERM, `TMS_OFF_HYST, `TMS_OFF_CONSEC,
            `TMS_OFF_SHSEL, `TMS_OFF_APD, `TMS_OFF_BETA: wr_ok = 1'h1;
            default: wr_ok = 1'h0;
        endcase
    end
    wire wr_en = do_wr && wr_ok && wstb_q;
    wire [7:0] wb = w_q[7:0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'h1;
            s_axi_wready  <= 1'h1;
            s_axi_bvalid  <= 1'h0;
            s_axi_bresp   <= `TMS_RESP_OK;
            aw_q          <= 8'h00;
            w_q           <= 32'h0000_0000;
            wstb_q        <= 1'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q          <= s_axi_awaddr;
                s_axi_awready <= 1'h0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q          <= s_axi_wdata;
                wstb_q       <= s_axi_wstrb[0];
                s_axi_wready <= 1'h0;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'h1;
                s_axi_bresp  <= wr_ok ? `TMS_RESP_OK : `TMS_RESP_ERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'h0;
                s_axi_awready <= 1'h1;
                s_axi_wready  <= 1'h1;
            end
        end
    end

    wire [7:0] wa = {aw_q[7:2], 2'h0};
    always @(posedge aclk) begin
        if (!aresetn) begin
            cfg                    <= 3'h0;
            rate_select            <= `TMS_RST_RATE;
            lim_high               <= `TMS_RST_HIGH;
            lim_low                <= `TMS_RST_LOW;
            lim_therm              <= `TMS_RST_THERM;
            hyst                   <= `TMS_RST_HYST;
            consec                 <= `TMS_RST_CONSEC;
            shsel                  <= 5'h00;
            antiparallel_pair_mode <= 2'h0;
            beta_req               <= 4'h0;
        end else if (wr_en) begin
            case (wa)
                `TMS_OFF_CFG: begin
                    cfg[2:1] <= wb[2:1];
                    cfg[`TMS_CFG_STBY] <= wb[`TMS_CFG_STBY] & ~HAS_SHDN;
                end
                `TMS_OFF_RATE:   rate_select            <= wb[3:0];
                `TMS_OFF_HIGH:   lim_high               <= wb;
                `TMS_OFF_LOW:    lim_low                <= wb;
                `TMS_OFF_THERM:  lim_therm              <= wb;
                `TMS_OFF_HYST:   hyst                   <= wb;
                `TMS_OFF_CONSEC: consec                 <= wb[2:0];
                `TMS_OFF_SHSEL:  shsel                  <= wb[4:0];
                `TMS_OFF_APD:    antiparallel_pair_mode <= wb[1:0];
                `TMS_OFF_BETA:   beta_req               <= wb[3:0];
                default: ;
            endcase
        end
    end

    // beta compensation gated by pair mode
    always @(posedge aclk) begin
        if (!aresetn)
            beta_en <= 4'h0;
        else
            beta_en <= beta_req & ~{antiparallel_pair_mode[1], antiparallel_pair_mode[1],
                                    antiparallel_pair_mode[0], antiparallel_pair_mode[0]};
    end

    // rate tick and conversion scheduler
    reg  [17:0] tick_cnt;
    reg  [10:0] per_cnt;
    reg         due;
    reg  [1:0]  state;
    reg  [2:0]  cur_ch;
    wire [17:0] tick_last = TICK_CYC32[17:0] - 18'h0_0001;
    wire        tick = (tick_cnt == tick_last);
    wire        os_wr = wr_en && (wa == `TMS_OFF_ONESHOT);

    always @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt   <= 18'h0_0000;
            per_cnt    <= 11'h000;
            due        <= 1'h0;
            os_pend    <= 1'h0;
            state      <= S_IDLE;
            cur_ch     <= 3'h0;
            meas_start <= 1'h0;
            meas_chan  <= 3'h0;
        end else begin
            meas_start <= 1'h0;
            tick_cnt   <= tick ? 18'h0_0000 : tick_cnt + 18'h0_0001;
            if (standby) begin
                per_cnt <= 11'h000;
            end else if (tick) begin
                if (per_cnt >= period - 11'h001) begin
                    per_cnt <= 11'h000;
                    due     <= 1'h1;
                end else begin
                    per_cnt <= per_cnt + 11'h001;
                end
            end
            if (os_wr && standby)
                os_pend <= 1'h1;
            case (state)
                S_IDLE: begin
                    if (due || os_pend) begin
                        due     <= 1'h0;
                        os_pend <= 1'h0;
                        cur_ch  <= 3'h0;
                        state   <= S_MEAS;
                    end
                end
                S_MEAS: begin
                    meas_start <= 1'h1;
                    meas_chan  <= cur_ch;
                    state      <= S_WAIT;
                end
                S_WAIT: begin
                    if (meas_done) begin
                        if (cur_ch == `TMS_LAST_CH) begin
                            state <= S_IDLE;
                        end else begin
                            cur_ch <= cur_ch + 3'h1;
                            state  <= S_MEAS;
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // per-channel limit checks
    wire        upd = (state == S_WAIT) && meas_done;
    wire        st_clr = s_axi_arvalid && s_axi_arready &&
                         ({s_axi_araddr[7:2], 2'h0} == `TMS_OFF_STATUS);
    wire signed [8:0] t9     = {meas_temp[7], meas_temp};
    wire signed [8:0] hi9    = {lim_high[7], lim_high};
    wire signed [8:0] lo9    = {lim_low[7], lim_low};
    wire signed [8:0] th9    = {lim_therm[7], lim_therm};
    wire signed [8:0] hw9    = {shdn_lim[7], shdn_lim};
    wire signed [8:0] hi_rel = hi9 - {1'h0, hyst};
    wire signed [8:0] th_rel = th9 - {1'h0, hyst};
    wire signed [8:0] hw_rel = hw9 - `TMS_SHDN_HYST;
    wire [39:0] res_w;
    wire [4:0]  st_hi;
    wire [4:0]  st_lo;
    wire [4:0]  st_flt;
    wire [4:0]  live_w;
    wire [4:0]  hs_w;
    wire [4:0]  ts_w;
    wire [4:0]  ws_w;
    wire [4:0]  sd_w;

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : ch
            localparam [2:0] CH = g;
            reg [7:0] r;
            reg       sh, sl, sf, live, hs, ts, ws;
            reg [2:0] tc, wc;
            wire hit    = upd && (cur_ch == CH);
            wire c_hi   = t9 > hi9;
            wire c_lo   = t9 <= lo9;
            wire use_hw = shsel[g] | (CH == 3'h1);
            wire hw_hit = shsel[g] ? (t9 > hw9) : (t9 >= hw9);
            always @(posedge aclk) begin
                if (!aresetn) begin
                    r  <= 8'h00;
                    sh <= 1'h0;
                    sl <= 1'h0;
                    sf <= 1'h0;
                    live <= 1'h0;
                    hs <= 1'h0;
                    ts <= 1'h0;
                    ws <= 1'h0;
                    tc <= 3'h0;
                    wc <= 3'h0;
                end else begin
                    if (hit) begin
                        r    <= meas_temp;
                        live <= c_hi | c_lo | meas_fault;
                        if (c_hi)
                            hs <= 1'h1;
                        else if (t9 < hi_rel)
                            hs <= 1'h0;
                        if (t9 >= th9) begin
                            if (tc != consec)
                                tc <= tc + 3'h1;
                            if ({1'h0, tc} + 4'h1 >= {1'h0, consec})
                                ts <= 1'h1;
                        end else begin
                            tc <= 3'h0;
                            if (t9 < th_rel)
                                ts <= 1'h0;
                        end
                        if (hw_hit) begin
                            if (wc != consec)
                                wc <= wc + 3'h1;
                            if ({1'h0, wc} + 4'h1 >= {1'h0, consec})
                                ws <= 1'h1;
                        end else begin
                            wc <= 3'h0;
                            if (t9 < hw_rel)
                                ws <= 1'h0;
                        end
                    end
                    // sticky flags: a new event beats a clearing read
                    if (hit && c_hi)
                        sh <= 1'h1;
                    else if (st_clr)
                        sh <= 1'h0;
                    if (hit && c_lo)
                        sl <= 1'h1;
                    else if (st_clr)
                        sl <= 1'h0;
                    if (hit && meas_fault)
                        sf <= 1'h1;
                    else if (st_clr)
                        sf <= 1'h0;
                end
            end
            assign res_w[8*g+7:8*g] = r;
            assign st_hi[g]  = sh;
            assign st_lo[g]  = sl;
            assign st_flt[g] = sf;
            assign live_w[g] = live;
            assign hs_w[g]   = hs;
            assign ts_w[g]   = ts;
            assign ws_w[g]   = ws;
            assign sd_w[g]   = use_hw ? ws : ts;
        end
    endgenerate

    // open-drain pin drivers
    reg od_low;
    wire irq_any = (|st_hi) | (|st_lo) | (|st_flt) | (|live_w);
    wire alert_on = cfg[`TMS_CFG_ATHM] ? (|hs_w) :
                    (~cfg[`TMS_CFG_MASK] & irq_any);
    always @(posedge aclk) begin
        if (!aresetn) begin
            od_low               <= 1'h0;
            alert_oe_n           <= 1'h1;
            therm_oe_n           <= 1'h1;
            hw_shutdown_pin_oe_n <= 1'h1;
        end else begin
            od_low               <= 1'h0;
            alert_oe_n           <= ~alert_on;
            therm_oe_n           <= ~(~HAS_SHDN & (|ts_w));
            hw_shutdown_pin_oe_n <= ~(HAS_SHDN & (|sd_w));
        end
    end
    assign alert_out           = od_low;
    assign therm_out           = od_low;
    assign hw_shutdown_pin_out = od_low;

    // AXI4-Lite read channel
    reg  [31:0] rd_data;
    reg         rd_ok;
    wire [5:0]  ridx = s_axi_araddr[7:2] - `TMS_RES_WORD;
    always @* begin
        rd_ok   = 1'h1;
        rd_data = 32'h0000_0000;
        case ({s_axi_araddr[7:2], 2'h0})
            `TMS_OFF_CFG:     rd_data[2:0] = cfg;
            `TMS_OFF_RATE:    rd_data[3:0] = rate_select;
            `TMS_OFF_ONESHOT: rd_data      = 32'h0000_0000;
            `TMS_OFF_HIGH:    rd_data[7:0] = lim_high;
            `TMS_OFF_LOW:     rd_data[7:0] = lim_low;
            `TMS_OFF_THERM:   rd_data[7:0] = lim_therm;
            `TMS_OFF_HYST:    rd_data[7:0] = hyst;
            `TMS_OFF_CONSEC:  rd_data[2:0] = consec;
            `TMS_OFF_SHSEL:   rd_data[4:0] = shsel;
            `TMS_OFF_APD:     rd_data[1:0] = antiparallel_pair_mode;
            `TMS_OFF_BETA:    rd_data[3:0] = beta_req;
            `TMS_OFF_STATUS:  rd_data[14:0] = {st_flt, st_lo, st_hi};
            `TMS_OFF_STATE:   rd_data = {scl_edges, 3'h0, sync2[3:1],
                                         beta_en, rate_eff,
                                         state != S_IDLE, standby};
            `TMS_OFF_THSTAT:  rd_data = {1'h0, client_addr, shdn_lim,
                                         1'h0, hs_w, ws_w, ts_w};
            default: begin
                if (ridx < `TMS_RES_COUNT)
                    rd_data[7:0] = res_w[{ridx[2:0], 3'h0} +: 8];
                else
                    rd_ok = 1'h0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'h1;
            s_axi_rvalid  <= 1'h0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `TMS_RESP_OK;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'h0;
                s_axi_rvalid  <= 1'h1;
                s_axi_rdata   <= rd_data;
                s_axi_rresp   <= rd_ok ? `TMS_RESP_OK : `TMS_RESP_ERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'h0;
                s_axi_arready <= 1'h1;
            end
        end
    end

endmodule
`default_nettype wire

// file: verif/tms_ctrl_sva.sv
`default_nettype none
module tms_ctrl_sva (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       meas_start,
    input wire logic [2:0] meas_chan,
    input wire logic       meas_done,
    input wire logic [7:0] meas_temp,
    input wire logic       hw_shutdown_pin_oe_n,
    input wire logic [2:0] shdn_pu_code,
    input wire logic [2:0] alert_pu_code
);
    timeunit 1ns;
    timeprecision 1ns;
    logic signed [9:0] lim;
    logic signed [9:0] set_at;
    logic signed [9:0] clr_at;
    // strap limit, then the lower of it and the default therm limit
    assign lim    = 10'sh03C + $signed({4'h0, shdn_pu_code, alert_pu_code});
    assign set_at = (lim < 10'sh064) ? lim : 10'sh064;
    assign clr_at = (lim - 10'sh00A > 10'sh05A) ? lim - 10'sh00A : 10'sh05A;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence mid_done;
        meas_done && meas_chan < 3'h4;
    endsequence
    sequence last_done;
        meas_done && meas_chan == 3'h4;
    endsequence
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    chk_start_pulse: assert property (meas_start |=> !meas_start)
        else $error("start pulse too long");
    chk_next_chan: assert property (mid_done |-> ##2 meas_start
        && meas_chan == $past(meas_chan, 2) + 3'h1) else $error("channel order broken");
    chk_last_idle: assert property (last_done |=> !meas_start [*2])
        else $error("no idle after last channel");
    chk_shdn_set: assert property ($fell(hw_shutdown_pin_oe_n) |-> $past(meas_done, 2)
        && $signed($past(meas_temp, 2)) >= set_at) else $error("shutdown set early");
    chk_shdn_clear: assert property ($rose(hw_shutdown_pin_oe_n) |-> $past(meas_done, 2)
        && $signed($past(meas_temp, 2)) < clr_at) else $error("shutdown released early");
    chk_wr_answer: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
        && !s_axi_arready) else $error("read answer late");
endmodule
`default_nettype wire

// file: verif/tms_conv_model.sv
`default_nettype none
module tms_conv_model (
    input  wire logic       aclk,
    input  wire logic       meas_start,
    input  wire logic [2:0] meas_chan,
    input  wire logic [7:0] t_ext1,
    input  wire logic [7:0] lat,
    output var  logic       meas_done,
    output wire logic [7:0] meas_temp,
    output var  logic       meas_fault
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       busy = 1'b0;
    logic [7:0] tq   = 8'h5A;
    logic [7:0] cnt;
    logic [2:0] ch;
    assign meas_temp = tq;
    // answers lat+1 cycles after a start; temperature bus toggles while idle and holds while a conversion counts down
    always @(posedge aclk) begin
        meas_done <= 1'b0;
        meas_fault <= 1'b0;
        if (meas_start) begin
            busy <= 1'b1;
            cnt <= lat;
            ch <= meas_chan;
        end else if (busy && cnt == 8'h00) begin
            busy <= 1'b0;
            meas_done <= 1'b1;
            tq <= (ch == 3'h1) ? t_ext1 : 8'h19;
        end else if (busy) begin
            cnt <= cnt - 8'h01;
        end else begin
            tq <= ~tq;
        end
    end
endmodule
`default_nettype wire

// file: verif/test_tms_ctrl.sv
`default_nettype none
`include "tms_map.vh"
module test_tms_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, scl_in, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, meas_start, meas_done, meas_fault;
    logic        alert_out, alert_oe_n, therm_out, therm_oe_n, hw_shutdown_pin_out;
    logic        hw_shutdown_pin_oe_n;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [2:0]  meas_chan, shdn_pu_code, alert_pu_code, therm_pu_code;
    logic [3:0]  s_axi_wstrb, beta_en;
    logic [6:0]  client_addr;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, meas_temp, t_ext1, lat;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [17:0] ov = 18'h1_FE7F;
    wire logic   alert_in, therm_in, hw_shutdown_pin_in;
    int          mismatches = 0, n_checks = 0, cyc = 0, n;
    logic [3:0]  rc [9] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hB, 4'hF};
    int          per [9] = '{640, 640, 640, 320, 160, 80, 40, 640, 640};
    logic [7:0]  tv [18] = '{8'h46, 8'h46, 8'h46, 8'h45, 8'h46, 8'h46, 8'h46, 8'h46, 8'h3D,
                             8'h3B, 8'h46, 8'h46, 8'h46, 8'h46, 8'h47, 8'h47, 8'h47, 8'h47};
    // open-drain pins with pull-ups
    assign alert_in = alert_oe_n | alert_out;
    assign therm_in = therm_oe_n | therm_out;
    assign hw_shutdown_pin_in = hw_shutdown_pin_oe_n | hw_shutdown_pin_out;
    tms_ctrl #(.TICK_CYCLES(10)) i_dut (.*);
    tms_conv_model i_conv (.*);
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task wait_start;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!(meas_start && meas_chan == 3'h0));
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            close_out;
        end
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
        {s_axi_rready, scl_in, s_axi_awaddr, s_axi_araddr} = 18'h1_0000;
        {s_axi_wdata, s_axi_wstrb} = 36'h0_0000_000F;
        {shdn_pu_code, alert_pu_code, therm_pu_code} = 9'h053;
        t_ext1 = 8'h19;
        lat = 8'h01;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`TMS_OFF_RATE);
        chk(d, 32'h0000_0006);
        rd(`TMS_OFF_THSTAT);
        chk({17'h0_0000, d[30:16]}, 32'h0000_4F46);
        chk({25'h000_0000, client_addr}, 32'h0000_004F);
        for (int i = 0; i < 9; i++) begin
            wr(`TMS_OFF_RATE, {28'h000_0000, rc[i]});
            wait_start;
            wait_start;
            chk(n, per[i]);
        end
        $display("rate table done");
        wr(`TMS_OFF_RATE, 32'h0000_0007);
        lat <= 8'h03;
        for (int i = 0; i < 18; i++) begin
            if (i == 10)
                wr(`TMS_OFF_SHSEL, 32'h0000_0002);
            t_ext1 <= tv[i];
            do @(posedge aclk); while (!(meas_done && meas_chan == 3'h1));
            repeat (3) @(posedge aclk);
            chk(32'(hw_shutdown_pin_oe_n), 32'(ov[i]));
        end
        $display("shutdown sequence done");
        wr(`TMS_OFF_CFG, 32'h0000_0001);
        rd(`TMS_OFF_STATE);
        chk(d & 32'h0000_0001, 32'h0000_0000);
        wr(`TMS_OFF_APD, 32'h0000_0001);
        wr(`TMS_OFF_BETA, 32'h0000_000F);
        repeat (3) @(posedge aclk);
        chk({28'h000_0000, beta_en}, 32'h0000_000C);
        rd(8'h44);
        chk(d, 32'h0000_0047);
        chk(32'(therm_oe_n), 32'h0000_0001);
        chk(32'(alert_oe_n), 32'h0000_0001);
        wr(`TMS_OFF_HIGH, 32'h0000_0040);
        do @(posedge aclk); while (!(meas_done && meas_chan == 3'h1));
        repeat (3) @(posedge aclk);
        chk(32'(alert_oe_n), 32'h0000_0000);
        rd(`TMS_OFF_STATUS);
        chk(d & 32'h0000_0002, 32'h0000_0002);
        wr(`TMS_OFF_CFG, 32'h0000_0004);
        repeat (3) @(posedge aclk);
        chk(32'(alert_oe_n), 32'h0000_0001);
        rd(8'h3C);
        chk({d[29:0], r}, 32'h0000_0002);
        wr(8'h3C, 32'h0000_0001);
        chk({30'h0000_0000, r}, 32'h0000_0002);
        repeat (8) begin
            repeat (4) @(posedge aclk);
            scl_in <= 1'b0;
            repeat (4) @(posedge aclk);
            scl_in <= 1'b1;
        end
        repeat (5) @(posedge aclk);
        rd(`TMS_OFF_STATE);
        chk({16'h0000, d[31:16]}, 32'h0000_0008);
        $display("register checks done");
        close_out;
    end
endmodule
bind tms_ctrl tms_ctrl_sva i_sva (.*);
`default_nettype wire
